// *** rtl/mcb_bank.sv ***
// misc config register bank: bias enables, port-2 modes, option bits
//
// Our own choice: strobed register access.
`timescale 1ns/1ns
// Overview of operation
// - Bias bit 2 drives P3.6 with a half-supply bias regardless of pin mode, reset 0.
// - Bias bit 1 drives P1.7 with a half-supply bias overriding pin mode, reset 0.
// - Bias bit 0 drives P1.6 with a half-supply bias regardless of pin mode, reset 0.
// - Port-2 mode holds bits 3:2 for P2.1 and 1:0 for P2.0, code 11 undefined, reset 01.
// - Option bit 7 puts the serial port in single-wire mode on P3.1, reset 0.
// - Option bit 6 enables touch oscillator auto-adjust, else it stays fixed, reset 0.
// - Option bits 5:4 pick watchdog period 480, 240, 120 or 60 ms, reset 00.
// - Option bits 3:2 pick converter clock as system clock over 32, 16, 8 or 4, reset 00.
module mcb_bank
  import mcb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  // pin bias overrides
  output logic bias_out_p36_enable,
  output logic bias_out_p17_enable,
  output logic bias_out_p16_enable,
  // port-2 pin modes
  output logic [1:0] pin21_mode_field,
  output logic [1:0] pin20_mode_field,
  output logic pin21_mode_undef,
  output logic pin20_mode_undef,
  // option controls
  output logic single_wire_serial_enable,
  output logic touch_osc_auto_adjust,
  output logic [1:0] watchdog_period_select,
  output logic [1:0] converter_clock_divider,
  output logic [9:0] watchdog_period_ms,
  output logic converter_clock_tick
);
  logic [2:0] bias_reg;
  logic [3:0] p2mode_reg;
  logic [7:0] option_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic hit_bias;
  logic hit_p2;
  logic hit_opt;

  function automatic logic [9:0] wdt_ms(input logic [1:0] code);
    case (code)
      2'h0: wdt_ms = 10'(WDT_MS_0);
      2'h1: wdt_ms = 10'(WDT_MS_1);
      2'h2: wdt_ms = 10'(WDT_MS_2);
      default: wdt_ms = 10'(WDT_MS_3);
    endcase
  endfunction

  assign hit_bias = (addr == BIAS_ADDR);
  assign hit_p2 = (addr == P2MODE_ADDR);
  assign hit_opt = (addr == OPTION_ADDR);

  // unimplemented bits and unmapped addresses read zero
  assign rdata_next = hit_bias ? {5'h00, bias_reg} :
                      hit_p2 ? {4'h0, p2mode_reg} :
                      hit_opt ? {option_reg[7:2], 2'h0} : 8'h00;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      bias_reg <= BIAS_RST;
    end else if (wr && hit_bias) begin
      bias_reg <= wdata[2:0] & BIAS_MASK_W;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      p2mode_reg <= {PIN_MODE_RST, PIN_MODE_RST};
    end else if (wr && hit_p2) begin
      p2mode_reg <= wdata[3:0];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      option_reg <= {1'b0, 1'b0, FIELD2_RST, FIELD2_RST, 2'h0};
    end else if (wr && hit_opt) begin
      option_reg <= {wdata[7:2], 2'h0};
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 8'h00;
    end else if (rd) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 8'h00;
    end
  end
  assign rdata = rdata_reg;

  // override is absolute; pad logic gives bias priority over mode
  assign bias_out_p36_enable = bias_reg[BIAS_P36_BIT];
  assign bias_out_p17_enable = bias_reg[BIAS_P17_BIT];
  assign bias_out_p16_enable = bias_reg[BIAS_P16_BIT];
  assign pin21_mode_field = p2mode_reg[PIN21_LSB +: 2];
  assign pin20_mode_field = p2mode_reg[PIN20_LSB +: 2];
  // code 11 kept as written but flagged so the pad can ignore it
  assign pin21_mode_undef = (pin21_mode_field == PIN_MODE_UNDEF);
  assign pin20_mode_undef = (pin20_mode_field == PIN_MODE_UNDEF);
  assign single_wire_serial_enable = option_reg[SW_SERIAL_BIT];
  assign touch_osc_auto_adjust = option_reg[TOUCH_ADJ_BIT];
  assign watchdog_period_select = option_reg[WDT_LSB +: 2];
  assign watchdog_period_ms = wdt_ms(watchdog_period_select);
  assign converter_clock_divider = option_reg[ADCK_LSB +: 2];

  mcb_adc_clkdiv u_adc_div (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .sel(converter_clock_divider),
    .tick(converter_clock_tick)
  );

  // assertions
  property p_bias_write;
    @(posedge sys_clk) disable iff (!resetn)
    (wr && hit_bias) |=> (bias_out_p36_enable == $past(wdata[2]))
      && (bias_out_p17_enable == $past(wdata[1])) && (bias_out_p16_enable == $past(wdata[0]));
  endproperty
  a_bias_write: assert property (p_bias_write) else $error("bias bits not updated");

  property p_p17_hold;
    @(posedge sys_clk) disable iff (!resetn)
    !(wr && hit_bias) |=> $stable(bias_out_p17_enable);
  endproperty
  a_p17_hold: assert property (p_p17_hold) else $error("p17 bias changed unwritten");

  property p_p16_read;
    @(posedge sys_clk) disable iff (!resetn)
    (rd && hit_bias) |=> (rdata[0] == bias_out_p16_enable) && (rdata[7:3] == 5'h00);
  endproperty
  a_p16_read: assert property (p_p16_read) else $error("p16 bias readback wrong");

  property p_p2_write;
    @(posedge sys_clk) disable iff (!resetn)
    (wr && hit_p2) |=> (pin21_mode_field == $past(wdata[3:2]))
      && (pin20_mode_field == $past(wdata[1:0]));
  endproperty
  a_p2_write: assert property (p_p2_write) else $error("port2 mode not updated");

  property p_serial;
    @(posedge sys_clk) disable iff (!resetn)
    (wr && hit_opt) |=> single_wire_serial_enable == $past(wdata[7]);
  endproperty
  a_serial: assert property (p_serial) else $error("single wire bit wrong");

  property p_touch;
    @(posedge sys_clk) disable iff (!resetn)
    !(wr && hit_opt) |=> $stable(touch_osc_auto_adjust);
  endproperty
  a_touch: assert property (p_touch) else $error("touch adjust changed unwritten");

  property p_wdt;
    @(posedge sys_clk) disable iff (!resetn)
    watchdog_period_ms == ((watchdog_period_select == 2'h0) ? 10'h1e0 :
                           (watchdog_period_select == 2'h1) ? 10'h0f0 :
                           (watchdog_period_select == 2'h2) ? 10'h078 : 10'h03c);
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog period wrong");

  property p_adc_div4;
    @(posedge sys_clk) disable iff (!resetn)
    // spacing only judged while the code holds; a code change does not restart the count
    (converter_clock_tick && converter_clock_divider == 2'h3)
      ##1 (converter_clock_divider == 2'h3)[*4] |-> converter_clock_tick;
  endproperty
  a_adc_div4: assert property (p_adc_div4) else $error("divide by 4 spacing wrong");

  property p_opt_read;
    @(posedge sys_clk) disable iff (!resetn)
    (rd && hit_opt) |=> rdata == {$past(option_reg[7:2]), 2'h0};
  endproperty
  a_opt_read: assert property (p_opt_read) else $error("option readback wrong");

  property p_unmapped;
    @(posedge sys_clk) disable iff (!resetn)
    (rd && !hit_bias && !hit_p2 && !hit_opt) |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_bias_hold;
    @(posedge sys_clk) disable iff (!resetn)
    !(wr && hit_bias) |=> $stable(bias_out_p36_enable) && $stable(bias_out_p16_enable);
  endproperty
  a_bias_hold: assert property (p_bias_hold) else $error("bias bits changed unwritten");

  property p_p2_hold;
    @(posedge sys_clk) disable iff (!resetn)
    !(wr && hit_p2) |=> $stable(pin21_mode_field) && $stable(pin20_mode_field);
  endproperty
  a_p2_hold: assert property (p_p2_hold) else $error("port2 mode changed unwritten");

  property p_opt_hold;
    @(posedge sys_clk) disable iff (!resetn)
    !(wr && hit_opt) |=> $stable(single_wire_serial_enable)
      && $stable(watchdog_period_select) && $stable(converter_clock_divider);
  endproperty
  a_opt_hold: assert property (p_opt_hold) else $error("option field changed unwritten");

  property p_opt_write;
    @(posedge sys_clk) disable iff (!resetn)
    (wr && hit_opt) |=> (touch_osc_auto_adjust == $past(wdata[6]))
      && (watchdog_period_select == $past(wdata[5:4]))
      && (converter_clock_divider == $past(wdata[3:2]));
  endproperty
  a_opt_write: assert property (p_opt_write) else $error("option fields not updated");

  // read data must not linger, or a stale value could be taken as a fresh read
  property p_rdata_idle;
    @(posedge sys_clk) disable iff (!resetn)
    !rd |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

  c_bias: cover property (@(posedge sys_clk) disable iff (!resetn) wr && hit_bias);
  c_p2_undef: cover property (@(posedge sys_clk) disable iff (!resetn) pin21_mode_undef);
  c_opt_rd: cover property (@(posedge sys_clk) disable iff (!resetn) rd && hit_opt);
  c_div4: cover property (@(posedge sys_clk) disable iff (!resetn)
    converter_clock_divider == 2'h3 && converter_clock_tick);
endmodule

// *** rtl/mcb_pkg.sv ***
// register map, field layout and reset values of the misc config bank
package mcb_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] BIAS_ADDR = 8'h92;
  localparam logic [7:0] P2MODE_ADDR = 8'h93;
  localparam logic [7:0] OPTION_ADDR = 8'h94;
  // bias enable bits
  localparam int BIAS_P36_BIT = 2;
  localparam int BIAS_P17_BIT = 1;
  localparam int BIAS_P16_BIT = 0;
  localparam logic [2:0] BIAS_RST = 3'h0;
  localparam logic [2:0] BIAS_MASK_W = 3'h7;
  // port-2 mode fields
  localparam int PIN21_LSB = 2;
  localparam int PIN20_LSB = 0;
  localparam logic [1:0] PIN_MODE_RST = 2'h1;
  localparam logic [1:0] PIN_MODE_UNDEF = 2'h3;
  // option fields
  localparam int SW_SERIAL_BIT = 7;
  localparam int TOUCH_ADJ_BIT = 6;
  localparam int WDT_LSB = 4;
  localparam int ADCK_LSB = 2;
  localparam logic [1:0] FIELD2_RST = 2'h0;
  // watchdog periods in ms, by code
  localparam int WDT_MS_0 = 480;
  localparam int WDT_MS_1 = 240;
  localparam int WDT_MS_2 = 120;
  localparam int WDT_MS_3 = 60;
  // converter clock divide ratios by code
  localparam logic [5:0] ADC_DIV_0 = 6'h20;
  localparam logic [5:0] ADC_DIV_1 = 6'h10;
  localparam logic [5:0] ADC_DIV_2 = 6'h08;
  localparam logic [5:0] ADC_DIV_3 = 6'h04;
  typedef enum logic [1:0] {
    MCB_MODE0 = 2'b00,
    MCB_MODE1 = 2'b01,
    MCB_MODE2 = 2'b10,
    MCB_MODE_UNDEF = 2'b11
  } mcb_pin_mode_e;
endpackage

// *** rtl/mcb_adc_clkdiv.sv ***
// converter clock divider steered by the option register
`timescale 1ns/1ns
module mcb_adc_clkdiv
  import mcb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // divide select code
  input wire logic [1:0] sel,
  // divided clock enable pulse
  output logic tick
);
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic [5:0] ratio;
  logic tick_reg;
  logic wrap;

  assign ratio = (sel == 2'h0) ? ADC_DIV_0 :
                 (sel == 2'h1) ? ADC_DIV_1 :
                 (sel == 2'h2) ? ADC_DIV_2 : ADC_DIV_3;
  // compare with >= so a ratio drop mid-count never overruns
  assign wrap = (cnt_reg >= ratio - 6'h01);
  assign cnt_next = wrap ? 6'h00 : cnt_reg + 6'h01;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 6'h00;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= wrap;
    end
  end
  assign tick = tick_reg;
endmodule

// *** verification/tb_top.sv ***
// self-checking bench for the misc config register bank
`timescale 1ns/1ns
module tb_top;
  import mcb_pkg::*;
  logic sys_clk, resetn, wr, rd;
  logic [7:0] addr, wdata, rdata, rv;
  logic b36, b17, b16, u21, u20, sws, toa, tick;
  logic [1:0] m21, m20, wps, ccd;
  logic [9:0] wms;
  int n_errors = 0;
  int n_tests = 0;
  mcb_bank dut_u (.sys_clk(sys_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .bias_out_p36_enable(b36), .bias_out_p17_enable(b17),
    .bias_out_p16_enable(b16), .pin21_mode_field(m21), .pin20_mode_field(m20),
    .pin21_mode_undef(u21), .pin20_mode_undef(u20), .single_wire_serial_enable(sws),
    .touch_osc_auto_adjust(toa), .watchdog_period_select(wps),
    .converter_clock_divider(ccd), .watchdog_period_ms(wms), .converter_clock_tick(tick));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
    #1;
  endtask
  // read data stands one cycle only, then returns to zero
  task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr <= a; rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
    @(posedge sys_clk);
    #1 chk(rdata, 8'h00);
  endtask
  task automatic t_reset();
    reg_rd(BIAS_ADDR, 8'h00);
    reg_rd(P2MODE_ADDR, 8'h05);
    reg_rd(OPTION_ADDR, 8'h00);
    chk({b36, b17, b16, u21, u20, sws, toa}, 16'h0000);
    chk({m21, m20, wps, ccd}, 16'h0050);
    chk(wms, 16'd480);
  endtask
  task automatic t_bias();
    for (int i = 0; i < 8; i++) begin
      reg_wr(BIAS_ADDR, {5'h1f, i[2:0]});
      chk(b36, i[2]);
      chk(b17, i[1]);
      chk(b16, i[0]);
      reg_rd(BIAS_ADDR, {5'h00, i[2:0]});
    end
  endtask
  task automatic t_p2mode();
    for (int c = 0; c < 4; c++) begin
      reg_wr(P2MODE_ADDR, {4'hf, c[1:0], ~c[1:0]});
      chk({m21, m20}, {c[1:0], ~c[1:0]});
      chk({u21, u20}, {c == 3, c == 0});
      reg_rd(P2MODE_ADDR, {4'h0, c[1:0], ~c[1:0]});
    end
  endtask
  task automatic t_option();
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {i[0], ~i[0], i[1:0], ~i[1:0], 2'h3};
      reg_wr(OPTION_ADDR, d);
      chk(sws, i[0]);
      chk(toa, {~i[0]});
      chk(wps, i[1:0]);
      chk(wms, 16'd480 >> i);
      chk(ccd, {~i[1:0]});
      reg_rd(OPTION_ADDR, d & 8'hfc);
    end
  endtask
  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (tick !== 1'b1 && n < 80);
    if (n >= 80) begin
      n_errors++;
      summarize();
    end
  endtask
  task automatic t_tick();
    int n;
    for (int c = 0; c < 4; c++) begin
      reg_wr(OPTION_ADDR, {4'h0, c[1:0], 2'h0});
      wait_tick(n);
      wait_tick(n);
      wait_tick(n);
      chk(n, 16'd32 >> c);
    end
  endtask
  // unmapped places neither store nor disturb the bank
  task automatic t_unmapped();
    reg_wr(BIAS_ADDR, 8'h05);
    reg_wr(8'h95, 8'hff);
    reg_wr(8'h91, 8'hff);
    reg_rd(8'h95, 8'h00);
    reg_rd(8'h91, 8'h00);
    reg_rd(BIAS_ADDR, 8'h05);
    reg_rd(P2MODE_ADDR, 8'h0c);
    reg_rd(OPTION_ADDR, 8'h0c);
    chk({b36, b17, b16}, 16'h0005);
  endtask
  initial begin
    resetn <= 1'b0;
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= 8'h00;
    wdata <= 8'h00;
    repeat (12) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    t_bias();
    t_p2mode();
    t_option();
    t_tick();
    t_unmapped();
    // second reset in mid-run must restore every field
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    t_reset();
    summarize();
  end
endmodule
